// [include/nvs_defines.svh]
// Constants for the two-wire nonvolatile memory slave.
`ifndef NVS_DEFINES_SVH
`define NVS_DEFINES_SVH

// Memory geometry.
`define NVS_ADDR_W     11
`define NVS_DEPTH      2048
`define NVS_DATA_W     8

// Bit counter values within one byte frame.
`define NVS_LAST_BIT   4'h7
`define NVS_ACK_BIT    4'h8

// Device word field positions.
`define NVS_TYPE_MSB   7
`define NVS_TYPE_LSB   4
`define NVS_UP_MSB     3
`define NVS_UP_LSB     1
`define NVS_RW_POS     0

// Reset values.
`define NVS_ADDR_RST   11'h000
`define NVS_BYTE_RST   8'h00
`define NVS_CNT_RST    4'h0

`endif

// [include/nvs_pkg.sv]
// Types shared by the nonvolatile memory slave.
package nvs_pkg;

    // Link-side protocol states, one-hot.
    typedef enum logic [4:0] {
        NVS_IDLE  = 5'h01,
        NVS_DEVW  = 5'h02,
        NVS_ADDR  = 5'h04,
        NVS_WDATA = 5'h08,
        NVS_RDATA = 5'h10
    } nvs_state_e;

endpackage

// [src/nvs_i2c_slave.sv]
// Two-wire slave access logic for a 2048 x 8 nonvolatile memory.
`timescale 1ns/10ps
`include "nvs_defines.svh"
//
// Functional notes
// - Receiver pulls data low on ninth clock.
// - Transmitter releases data on ninth clock.
// - Stop before acknowledge abandons current operation.
// - After not-acknowledge, release data line.
// - Address built from upper bits and byte.
// - Current read takes low bits from buffer.
// - Device word: type, upper address, direction.
// - Type mismatch means standby, no access.
// - Upper bits are address, never compared.
// - Direction bit zero writes, one reads.
// - Acknowledge device word and address byte.
// - Acknowledge every received data byte.
// - Never withhold acknowledge for busy writes.
// - Write protect high blocks all writes.
// - Byte write: word, address, data, stop.
// - Following bytes go to next address, wrapping.
// - Buffer keeps address only after stop.
// - Current read returns buffered address plus one.
// - Random read uses repeated start sequence.
// - Acknowledged reads continue at next address.
// - Sample on rising, drive after falling clock.
// - Start and stop are data edges, clock high.
// - Stop ends any operation, enters standby.

module nvs_i2c_slave #(
    parameter logic [3:0] DEV_TYPE = 4'h5   // Arbitrary type code value.
) (
    // System clock and reset.
    input  wire logic clk,
    input  wire logic rst,
    // Serial link clock from the master.
    input  wire logic scl_in,
    // Serial data pin, open drain.
    input  wire logic sda_in,
    output logic      sda_out,
    output logic      sda_oe,
    // Write protect pin.
    input  wire logic write_protect,
    // Status towards the system side.
    output logic      bus_active,
    output logic      write_blocked
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations.

    nvs_pkg::nvs_state_e          state;
    logic [3:0]                   bitcnt;
    logic [`NVS_DATA_W-1:0]       shreg;
    logic [`NVS_DATA_W-1:0]       tx;
    logic [2:0]                   upper;
    logic                         addr_set;
    logic                         accessed;
    logic [`NVS_ADDR_W-1:0]       cur_addr;
    logic [`NVS_ADDR_W-1:0]       last_addr;
    logic [`NVS_ADDR_W-1:0]       addr_buf;
    logic [`NVS_ADDR_W-1:0]       next_rd;
    logic [`NVS_DATA_W-1:0]       mem [0:`NVS_DEPTH-1];
    logic                         start_tgl;
    logic                         start_ack;
    logic                         stop_tgl;
    logic                         stop_ack;
    logic                         start_pend;
    logic                         stop_pend;
    logic                         wp_s1;
    logic                         wp_s;
    logic                         wr_en;
    logic                         blk_tgl;
    logic                         idle_s1;
    logic                         idle_s2;
    logic [2:0]                   blk_s;

    // Checks whether a device word carries the fixed type code.
    function automatic logic type_match(input logic [7:0] w);
        type_match = (w[`NVS_TYPE_MSB:`NVS_TYPE_LSB] == DEV_TYPE);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Start and stop detection on data edges while the clock is high.

    // A falling data edge with the clock high marks a start.
    always_ff @(negedge sda_in or posedge rst) begin
        if (rst) begin
            start_tgl <= 1'b0;
        end else if (scl_in) begin
            start_tgl <= ~start_tgl;
        end
    end

    // A rising data edge with the clock high marks a stop.
    always_ff @(posedge sda_in or posedge rst) begin
        if (rst) begin
            stop_tgl <= 1'b0;
        end else if (scl_in) begin
            stop_tgl <= ~stop_tgl;
        end
    end

    // Pending events are handled at the next clock edge of the link.
    assign start_pend = start_tgl ^ start_ack;
    assign stop_pend  = stop_tgl ^ stop_ack;

    ////////////////////////////////////////////////////////////////////////
    // Link domain: write protect synchroniser.

    // The protect level is held stable by the master during a frame.
    always_ff @(posedge scl_in or posedge rst) begin
        if (rst) begin
            wp_s1 <= 1'b0;
            wp_s  <= 1'b0;
        end else begin
            wp_s1 <= write_protect;
            wp_s  <= wp_s1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Link domain: address arithmetic and memory write strobe.

    // A current read continues at the buffered address plus one.
    always_comb begin
        if (addr_set) begin
            next_rd = {shreg[`NVS_UP_MSB:`NVS_UP_LSB], cur_addr[7:0]};
        end else begin
            next_rd = {shreg[`NVS_UP_MSB:`NVS_UP_LSB], addr_buf[7:0]}
                      + 11'h001;
        end
    end

    // Data is stored only at the acknowledge clock, never with protect.
    assign wr_en = !start_pend && !stop_pend && (state == nvs_pkg::NVS_WDATA)
                   && (bitcnt == `NVS_ACK_BIT) && !wp_s;

    // The array itself has no reset, matching its undefined power-up.
    always_ff @(posedge scl_in) begin
        if (wr_en) begin
            mem[cur_addr] <= shreg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Link domain: protocol sequencer, sampling on rising clock.

    // Receives bits, decodes the device word and steps the address.
    always_ff @(posedge scl_in or posedge rst) begin
        if (rst) begin
            state     <= nvs_pkg::NVS_IDLE;
            bitcnt    <= `NVS_CNT_RST;
            shreg     <= `NVS_BYTE_RST;
            tx        <= `NVS_BYTE_RST;
            upper     <= 3'h0;
            addr_set  <= 1'b0;
            accessed  <= 1'b0;
            cur_addr  <= `NVS_ADDR_RST;
            last_addr <= `NVS_ADDR_RST;
            addr_buf  <= `NVS_ADDR_RST;
            start_ack <= 1'b0;
            stop_ack  <= 1'b0;
            blk_tgl   <= 1'b0;
        end else if (start_pend) begin
            start_ack <= start_tgl;
            stop_ack  <= stop_tgl;
            if (stop_pend) begin
                addr_set <= 1'b0;
                accessed <= 1'b0;
                if (accessed) begin
                    addr_buf <= last_addr;
                end
            end
            state  <= nvs_pkg::NVS_DEVW;
            bitcnt <= 4'h1;
            shreg  <= {7'h00, sda_in};
        end else if (stop_pend) begin
            stop_ack <= stop_tgl;
            addr_set <= 1'b0;
            accessed <= 1'b0;
            if (accessed) begin
                addr_buf <= last_addr;
            end
            state  <= nvs_pkg::NVS_IDLE;
            bitcnt <= `NVS_CNT_RST;
        end else begin
            case (state)
                nvs_pkg::NVS_DEVW, nvs_pkg::NVS_ADDR,
                nvs_pkg::NVS_WDATA: begin
                    if (bitcnt != `NVS_ACK_BIT) begin
                        shreg  <= {shreg[6:0], sda_in};
                        bitcnt <= bitcnt + 4'h1;
                    end else begin
                        bitcnt <= `NVS_CNT_RST;
                        if (state == nvs_pkg::NVS_DEVW) begin
                            if (!type_match(shreg)) begin
                                state <= nvs_pkg::NVS_IDLE;
                            end else if (shreg[`NVS_RW_POS]) begin
                                upper     <= shreg[`NVS_UP_MSB:`NVS_UP_LSB];
                                tx        <= mem[next_rd];
                                last_addr <= next_rd;
                                cur_addr  <= next_rd + 11'h001;
                                accessed  <= 1'b1;
                                state     <= nvs_pkg::NVS_RDATA;
                            end else begin
                                // Upper bits are address, not a selector.
                                upper <=
                                    shreg[`NVS_UP_MSB:`NVS_UP_LSB];
                                state <= nvs_pkg::NVS_ADDR;
                            end
                        end else if (state == nvs_pkg::NVS_ADDR) begin
                            cur_addr <= {upper, shreg};
                            addr_set <= 1'b1;
                            state    <= nvs_pkg::NVS_WDATA;
                        end else begin
                            last_addr <= cur_addr;
                            cur_addr  <= cur_addr + 11'h001;
                            accessed  <= 1'b1;
                            if (wp_s) begin
                                blk_tgl <= ~blk_tgl;
                            end
                        end
                    end
                end
                nvs_pkg::NVS_RDATA: begin
                    if (bitcnt != `NVS_ACK_BIT) begin
                        tx     <= {tx[6:0], 1'b0};
                        bitcnt <= bitcnt + 4'h1;
                    end else begin
                        bitcnt <= `NVS_CNT_RST;
                        if (!sda_in) begin
                            tx        <= mem[cur_addr];
                            last_addr <= cur_addr;
                            cur_addr  <= cur_addr + 11'h001;
                        end else begin
                            state <= nvs_pkg::NVS_IDLE;
                        end
                    end
                end
                default: begin
                    bitcnt <= `NVS_CNT_RST;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Link domain: data line driver, changing on falling clock.

    // Pulls the line low for acknowledges and zero read bits only.
    always_ff @(negedge scl_in or posedge rst) begin
        if (rst) begin
            sda_oe <= 1'b0;
        end else if (start_pend || stop_pend) begin
            sda_oe <= 1'b0;
        end else begin
            case (state)
                nvs_pkg::NVS_DEVW: begin
                    sda_oe <= (bitcnt == `NVS_ACK_BIT)
                              && type_match(shreg);
                end
                nvs_pkg::NVS_ADDR, nvs_pkg::NVS_WDATA: begin
                    sda_oe <= (bitcnt == `NVS_ACK_BIT);
                end
                nvs_pkg::NVS_RDATA: begin
                    sda_oe <= (bitcnt != `NVS_ACK_BIT) && !tx[7];
                end
                default: begin
                    sda_oe <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // System domain: status crossing and constant pin level.

    // The pin level is always low; only the enable moves.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sda_out <= 1'b0;
        end else begin
            sda_out <= 1'b0;
        end
    end

    // Bring the idle state bit across as a level.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            idle_s1    <= 1'b1;
            idle_s2    <= 1'b1;
            bus_active <= 1'b0;
        end else begin
            idle_s1    <= state[0];
            idle_s2    <= idle_s1;
            bus_active <= ~idle_s2;
        end
    end

    // Turn each toggle of a blocked write into a single pulse.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            blk_s         <= 3'h0;
            write_blocked <= 1'b0;
        end else begin
            blk_s         <= {blk_s[1:0], blk_tgl};
            write_blocked <= blk_s[2] ^ blk_s[1];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks on the link behaviour.

    // Device word acknowledge follows the type code.
    dev_ack_a: assert property (
        @(posedge scl_in) disable iff (rst)
        (state == nvs_pkg::NVS_DEVW && bitcnt == `NVS_ACK_BIT
         && !start_pend && !stop_pend)
        |-> (sda_oe == (shreg[7:4] == DEV_TYPE)))
        else $error("Device word acknowledge does not follow type code.");

    // Address and data bytes are always acknowledged.
    data_ack_a: assert property (
        @(posedge scl_in) disable iff (rst)
        ((state == nvs_pkg::NVS_ADDR || state == nvs_pkg::NVS_WDATA)
         && bitcnt == `NVS_ACK_BIT && !start_pend && !stop_pend)
        |-> sda_oe)
        else $error("Received byte was not acknowledged.");

    // The line is released for the master acknowledge of read data.
    read_rel_a: assert property (
        @(posedge scl_in) disable iff (rst)
        (state == nvs_pkg::NVS_RDATA && bitcnt == `NVS_ACK_BIT)
        |-> !sda_oe)
        else $error("Line held during master acknowledge.");

    // Read bits match the transmit register.
    read_bit_a: assert property (
        @(posedge scl_in) disable iff (rst)
        (state == nvs_pkg::NVS_RDATA && bitcnt != `NVS_ACK_BIT
         && !start_pend && !stop_pend)
        |-> (sda_oe == !tx[7]))
        else $error("Read bit on the line differs from data.");

    // A lone stop returns the sequencer to idle.
    stop_idle_a: assert property (
        @(posedge scl_in) disable iff (rst)
        (stop_pend && !start_pend) |=> (state == nvs_pkg::NVS_IDLE))
        else $error("Stop did not end the operation.");

    // A start always restarts device word reception.
    start_word_a: assert property (
        @(posedge scl_in) disable iff (rst)
        start_pend |=> (state == nvs_pkg::NVS_DEVW && bitcnt == 4'h1))
        else $error("Start did not begin a new device word.");

    // A protected byte leaves its array cell unchanged.
    wp_block_a: assert property (
        @(posedge scl_in) disable iff (rst)
        (state == nvs_pkg::NVS_WDATA && bitcnt == `NVS_ACK_BIT && wp_s
         && !start_pend && !stop_pend)
        |=> (mem[last_addr] == $past(mem[cur_addr])))
        else $error("Write while protect is high.");

    // Each stored byte advances the address by one, wrapping.
    addr_step_a: assert property (
        @(posedge scl_in) disable iff (rst)
        wr_en |=> (cur_addr == $past(cur_addr) + 11'h001))
        else $error("Write address did not advance by one.");

    // A current read fetches the buffered address plus one.
    cur_read_a: assert property (
        @(posedge scl_in) disable iff (rst)
        (state == nvs_pkg::NVS_DEVW && bitcnt == `NVS_ACK_BIT
         && !start_pend && !stop_pend && type_match(shreg)
         && shreg[0] && !addr_set)
        |=> (last_addr == {$past(shreg[3:1]), $past(addr_buf[7:0])}
             + 11'h001))
        else $error("Current read address is not buffer plus one.");

    // A not-acknowledge from the master ends the read.
    nack_end_a: assert property (
        @(posedge scl_in) disable iff (rst)
        (state == nvs_pkg::NVS_RDATA && bitcnt == `NVS_ACK_BIT
         && sda_in && !start_pend && !stop_pend)
        |=> (state == nvs_pkg::NVS_IDLE) ##1 !sda_oe)
        else $error("Read continued after not-acknowledge.");

endmodule

// [tb/nvs_i2c_master_model.sv]
// Bus master model that drives the link of the memory slave.
`timescale 1ns/10ps

module nvs_i2c_master_model (
    // Link clock and open-drain data line.
    output logic      scl,
    output logic      sda_oe,
    input  wire logic sda
);
    // Extra low time before every bit, used to play a slow master.
    int stall_ns = 0;

    // The bus idles with the clock high and the data line released.
    initial begin
        scl = 1'b1;
        sda_oe = 1'b0;
    end

    // Start or repeated start: data falls while the clock is high.
    task automatic start();
        sda_oe = 1'b0;
        #8;
        scl = 1'b1;
        #15;
        sda_oe = 1'b1;
        #15;
        scl = 1'b0;
        #7;
    endtask

    // Stop: data rises while the clock is high, then the clock stands.
    task automatic stop();
        sda_oe = 1'b1;
        #8;
        scl = 1'b1;
        #15;
        sda_oe = 1'b0;
        #15;
    endtask

    // One bit: data changes only while the clock is low.
    task automatic bit_io(input logic b, output logic r);
        #(stall_ns);
        sda_oe = ~b;
        #8;
        scl = 1'b1;
        #7;
        r = sda;
        #8;
        scl = 1'b0;
        #7;
    endtask

    // Sends a byte MSB first and releases the line for the answer.
    task automatic write_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, r);
        ack = (r === 1'b0);
    endtask

    // Receives a byte, then acknowledges it or ends with a high bit.
    task automatic read_byte(input logic ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, d[i]);
        end
        bit_io(~ack, r);
    endtask
endmodule

// [tb/nvs_i2c_slave_test.sv]
// Self-checking bench for the two-wire memory slave.
`timescale 1ns/10ps

module nvs_i2c_slave_test;
    localparam logic [3:0] TYPE_CODE = 4'hC;  // Arbitrary type code value.
    logic clk;
    logic rst;
    logic scl;
    logic m_oe;
    logic sda;
    logic wp;
    logic dev_out;
    logic dev_oe;
    logic bus_active;
    logic write_blocked;
    int   error_cnt = 0;
    int   n_tests = 0;
    int   blk_cnt = 0;

    // The data wire is pulled up unless some party pulls it low.
    assign sda = (m_oe || (dev_oe && !dev_out)) ? 1'b0 : 1'b1;

    nvs_i2c_slave #(.DEV_TYPE(TYPE_CODE)) nvs_i2c_slave_inst (
        .clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda),
        .sda_out(dev_out), .sda_oe(dev_oe), .write_protect(wp),
        .bus_active(bus_active), .write_blocked(write_blocked));
    nvs_i2c_master_model nvs_i2c_master_model_inst (
        .scl(scl), .sda_oe(m_oe), .sda(sda));

    // The system clock runs at 10 MHz.
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Counts refused-write pulses on the system side.
    always @(posedge clk) begin
        if (write_blocked === 1'b1) blk_cnt <= blk_cnt + 1;
    end

    // The slave may only move its data drive while the clock is low.
    always @(dev_oe) begin
        if (rst === 1'b0) check({7'h00, scl}, 8'h00);
    end

    // Compares one value and reports a difference at once.
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Short names for the master's bus conditions.
    task automatic sta();
        nvs_i2c_master_model_inst.start();
    endtask
    task automatic sto();
        nvs_i2c_master_model_inst.stop();
    endtask

    // Sends a byte and checks the slave's answer on the ninth bit.
    task automatic send(input logic [7:0] d, input logic exp_ack);
        logic ack;
        nvs_i2c_master_model_inst.write_byte(d, ack);
        check({7'h00, ack}, {7'h00, exp_ack});
    endtask

    // Reads a byte, answers it, and checks the data and the drive value.
    task automatic rd(input logic ack, input logic [7:0] exp);
        logic [7:0] d;
        nvs_i2c_master_model_inst.read_byte(ack, d);
        check(d, exp);
        check({7'h00, dev_out}, 8'h00);
    endtask

    // Opens a write frame and loads the full address.
    task automatic set_addr(input logic [10:0] a);
        sta();
        send({TYPE_CODE, a[10:8], 1'b0}, 1'b1);
        send(a[7:0], 1'b1);
    endtask

    // Random read of one byte with a closing high answer.
    task automatic rand_rd(input logic [10:0] a, input logic [7:0] exp);
        set_addr(a);
        sta();
        send({TYPE_CODE, a[10:8], 1'b1}, 1'b1);
        rd(1'b0, exp);
        sto();
    endtask

    // Current-address read of one byte with the given upper bits.
    task automatic cur_rd(input logic [2:0] u, input logic [7:0] exp);
        sta();
        send({TYPE_CODE, u, 1'b1}, 1'b1);
        rd(1'b0, exp);
        sto();
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Byte write followed at once by a random read of it.
    task automatic t_byte_write();
        set_addr(11'h3A5);
        send(8'h5C, 1'b1);
        sto();
        rand_rd(11'h3A5, 8'h5C);
    endtask

    // Page write across the top address, then wrapping reads.
    task automatic t_page_wrap();
        set_addr(11'h7FE);
        send(8'h11, 1'b1);
        send(8'h22, 1'b1);
        send(8'h33, 1'b1);
        send(8'h44, 1'b1);
        check({7'h00, bus_active}, 8'h01);
        sto();
        set_addr(11'h7FE);
        sta();
        send({TYPE_CODE, 3'h7, 1'b1}, 1'b1);
        rd(1'b1, 8'h11);
        rd(1'b1, 8'h22);
        rd(1'b0, 8'h33);
        sto();
        cur_rd(3'h0, 8'h44);
        rand_rd(11'h7FF, 8'h22);
        cur_rd(3'h7, 8'h33);
    endtask

    // A wrong type code is never answered and changes nothing.
    task automatic t_bad_type();
        sta();
        send({TYPE_CODE ^ 4'h1, 3'h3, 1'b0}, 1'b0);
        sto();
        sta();
        send({TYPE_CODE ^ 4'h8, 3'h3, 1'b1}, 1'b0);
        sto();
        rand_rd(11'h3A5, 8'h5C);
    endtask

    // Protected writes are answered but leave the array untouched.
    task automatic t_protect();
        int base;
        wp <= 1'b1;
        @(posedge clk);
        base = blk_cnt;
        nvs_i2c_master_model_inst.stall_ns = 40;
        set_addr(11'h3A5);
        send(8'h99, 1'b1);
        sto();
        repeat (6) @(posedge clk);
        check(8'(blk_cnt - base), 8'h01);
        rand_rd(11'h3A5, 8'h5C);
        nvs_i2c_master_model_inst.stall_ns = 0;
        @(posedge clk);
        wp <= 1'b0;
        @(posedge clk);
    endtask

    // A stop or a start inside a data byte throws the byte away.
    task automatic t_abort();
        logic r;
        set_addr(11'h3A5);
        for (int i = 0; i < 4; i++) nvs_i2c_master_model_inst.bit_io(1'b0, r);
        sto();
        // Idle clocks after the stop let the slave settle into standby.
        for (int i = 0; i < 2; i++) nvs_i2c_master_model_inst.bit_io(1'b1, r);
        repeat (5) @(posedge clk);
        check({7'h00, bus_active}, 8'h00);
        rand_rd(11'h3A5, 8'h5C);
        set_addr(11'h3A5);
        for (int i = 0; i < 3; i++) nvs_i2c_master_model_inst.bit_io(1'b1, r);
        sta();
        send({TYPE_CODE, 3'h3, 1'b1}, 1'b1);
        rd(1'b0, 8'h5C);
        sto();
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Reset, then the scenarios in turn.
    initial begin
        rst = 1'b1;
        wp = 1'b0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        t_byte_write();
        t_page_wrap();
        t_bad_type();
        t_protect();
        t_abort();
        summarize();
    end

    // Cuts a hang short well after the scenarios should have finished.
    initial begin
        #500000;
        error_cnt++;
        $display("ERROR at %0t: watchdog expired", $time);
        summarize();
    end
endmodule
